// >>> lhcd_pkg.sv
// Package for the LCD host command decoder: opcodes, field layouts,
// reset values and the packed control/pointer carriers.
// Assumes the host byte strobes are synchronous to the system clock.
package lhcd_pkg;
   localparam logic [6:0] COL_MAX       = 7'h7f;
   localparam logic [4:0] BANK_MAX      = 5'h1f;
   localparam logic [6:0] SKIP_LO       = 7'h30;
   localparam logic [6:0] SKIP_HI       = 7'h4f;
   localparam logic [2:0] DE_PARTIAL    = 3'h5;
   localparam logic [1:0] RST_MUX       = 2'h3;
   localparam logic [1:0] RST_GAIN      = 2'h3;
   localparam logic [5:0] RST_TRIM      = 6'h10;
   localparam logic [3:0] RST_POWER     = 4'hc;
   localparam logic [6:0] RST_LIMIT     = 7'h7f;
   localparam logic [7:0] OP_LIMIT      = 8'h32;
   localparam logic [7:0] OP_BIAS       = 8'h81;

   typedef struct packed {
      logic [1:0] row_multiplex;
      logic [1:0] temp_slope;
      logic [3:0] power_config;
      logic [6:0] column_limit;
      logic [6:0] scroll_offset;
      logic [1:0] bias_gain;
      logic [5:0] bias_trim;
      logic [2:0] increment_setup;
      logic [3:0] fixed_pairs;
      logic [1:0] line_rate;
      logic       force_all_on;
      logic       invert_pixels;
      logic [2:0] driver_enable;
      logic       row_mirror;
      logic       column_mirror;
      logic       bit_pair_swap;
   } lhcd_ctrl_t;

   typedef struct packed {
      logic [4:0] bank;
      logic [6:0] column;
   } lhcd_addr_t;

   typedef enum logic [1:0] {
      ST_OPCODE = 2'b00,
      ST_LIMIT  = 2'b01,
      ST_BIAS   = 2'b10
   } lhcd_state_t;
endpackage

// >>> lhcd_decoder.sv
// Host command decoder: control fields, RAM pointer advance, data
// path with bit reordering, status byte.
// Assumes one-cycle write/read strobes on I_SYS_CLK from a host front end
// and a RAM port that answers a read in the same cycle as its read request.
`timescale 1ns/1ps
module lhcd_decoder (
   input  wire logic              I_SYS_CLK,
   input  wire logic              I_RST,
   input  wire logic              I_WR_STB,
   input  wire logic              I_RD_STB,
   input  wire logic              I_CD,
   input  wire logic [7:0]        I_WDATA,
   input  wire logic              I_BUSY,
   input  wire logic              I_RESET_PENDING,
   input  wire logic [7:0]        I_RAM_RDATA,
   output logic [7:0]             O_RDATA,
   output logic                   O_RDATA_VALID,
   output logic                   O_RAM_WE,
   output logic                   O_RAM_RE,
   output logic [11:0]            O_RAM_ADDR,
   output logic [7:0]             O_RAM_WDATA,
   output lhcd_pkg::lhcd_ctrl_t   O_CTRL,
   output lhcd_pkg::lhcd_addr_t   O_POINTERS,
   output logic                   O_DRIVERS_ON
);
   lhcd_pkg::lhcd_ctrl_t  ctrl;
   lhcd_pkg::lhcd_addr_t  ptr;
   lhcd_pkg::lhcd_state_t state;
   logic                  ram_rd_pend;

   // Host strobes are dropped entirely while reset is in progress
   wire logic acc_ok  = !I_RESET_PENDING;
   wire logic cmd_wr  = I_WR_STB && acc_ok && !I_CD;
   wire logic dat_wr  = I_WR_STB && acc_ok && I_CD;
   wire logic cmd_rd  = I_RD_STB && acc_ok && !I_CD;
   wire logic dat_rd  = I_RD_STB && acc_ok && I_CD;
   wire logic op_cmd  = cmd_wr && state == lhcd_pkg::ST_OPCODE;
   wire logic [7:0] b = I_WDATA;

   function automatic lhcd_pkg::lhcd_addr_t advance(
      input lhcd_pkg::lhcd_addr_t p,
      input lhcd_pkg::lhcd_ctrl_t c);
      lhcd_pkg::lhcd_addr_t n;
      logic [4:0] nb;
      logic [6:0] nc;
      logic       bank_end;
      n = p;
      // Bank wrap falls out of 5-bit arithmetic at 0 and 31
      nb = c.increment_setup[2] ? p.bank - 5'h1 : p.bank + 5'h1;
      nc = p.column + 7'h1;
      // Partial display hides the middle column group
      if (c.driver_enable == lhcd_pkg::DE_PARTIAL &&
          nc >= lhcd_pkg::SKIP_LO && nc <= lhcd_pkg::SKIP_HI)
         nc = lhcd_pkg::SKIP_HI + 7'h1;
      bank_end = c.increment_setup[2] ? (p.bank == 5'h0)
                                      : (p.bank == lhcd_pkg::BANK_MAX);
      if (c.increment_setup[1]) begin
         if (!bank_end)
            n.bank = nb;
         else if (p.column != c.column_limit) begin
            n.bank = nb;
            n.column = nc;
         end else if (c.increment_setup[0]) begin
            n.bank = nb;
            n.column = 7'h0;
         end
      end else if (p.column != c.column_limit) begin
         n.column = nc;
      end else if (c.increment_setup[0]) begin
         n.column = 7'h0;
         n.bank = nb;
      end
      return n;
   endfunction

   wire lhcd_pkg::lhcd_addr_t next_ptr_adv = advance(ptr, ctrl);
   wire logic [6:0] ram_col = ctrl.column_mirror ?
                              lhcd_pkg::COL_MAX - ptr.column
                              : ptr.column;
   wire logic [7:0] swapped = ctrl.bit_pair_swap ?
                              {b[1:0], b[3:2], b[5:4], b[7:6]} : b;
   wire logic [7:0] status = {I_BUSY, ctrl.column_mirror, O_DRIVERS_ON,
                              I_RESET_PENDING, ctrl.increment_setup[0],
                              ctrl.bias_gain, 1'b1};

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         state <= lhcd_pkg::ST_OPCODE;
      end else if (cmd_wr) begin
         case (state)
            lhcd_pkg::ST_OPCODE: begin
               if (b == lhcd_pkg::OP_LIMIT)
                  state <= lhcd_pkg::ST_LIMIT;
               else if (b == lhcd_pkg::OP_BIAS)
                  state <= lhcd_pkg::ST_BIAS;
            end
            default: state <= lhcd_pkg::ST_OPCODE;
         endcase
      end
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         ctrl <= '0;
         ctrl.row_multiplex <= lhcd_pkg::RST_MUX;
         ctrl.bias_gain <= lhcd_pkg::RST_GAIN;
         ctrl.bias_trim <= lhcd_pkg::RST_TRIM;
         ctrl.power_config <= lhcd_pkg::RST_POWER;
         ctrl.column_limit <= lhcd_pkg::RST_LIMIT;
      end else if (cmd_wr && state == lhcd_pkg::ST_LIMIT) begin
         ctrl.column_limit <= b[6:0];
      end else if (cmd_wr && state == lhcd_pkg::ST_BIAS) begin
         ctrl.bias_gain <= b[7:6];
         ctrl.bias_trim <= b[5:0];
      end else if (op_cmd) begin
         case (b[7:2])
            6'h08: ctrl.row_multiplex <= b[1:0];
            6'h09: ctrl.temp_slope <= b[1:0];
            6'h0a: ctrl.power_config[1:0] <= b[1:0];
            6'h0b: ctrl.power_config[3:2] <= b[1:0];
            6'h28: ctrl.line_rate <= b[1:0];
            default: begin
               if (b[7:4] == 4'h4)
                  ctrl.scroll_offset[3:0] <= b[3:0];
               if (b[7:3] == 5'h0a)
                  ctrl.scroll_offset[6:4] <= b[2:0];
               if (b[7:3] == 5'h11)
                  ctrl.increment_setup <= b[2:0];
               if (b[7:4] == 4'h9)
                  ctrl.fixed_pairs <= b[3:0];
               if (b[7:1] == 7'h52)
                  ctrl.force_all_on <= b[0];
               if (b[7:1] == 7'h53)
                  ctrl.invert_pixels <= b[0];
               if (b[7:3] == 5'h15)
                  ctrl.driver_enable <= b[2:0];
               if (b[7:3] == 5'h18)
                  {ctrl.row_mirror, ctrl.column_mirror,
                   ctrl.bit_pair_swap} <= b[2:0];
            end
         endcase
      end
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         ptr <= '0;
      end else if (dat_wr || dat_rd) begin
         ptr <= next_ptr_adv;
      end else if (op_cmd) begin
         if (b[7:4] == 4'h0)
            ptr.column[3:0] <= b[3:0];
         else if (b[7:3] == 5'h02)
            ptr.column[6:4] <= b[2:0];
         else if (b[7:4] == 4'h6)
            ptr.bank[3:0] <= b[3:0];
         else if (b[7:4] == 4'h7)
            ptr.bank[4] <= b[0];
      end
   end

   // RAM address is registered with the access so data lines up
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_RAM_WE <= 1'b0;
         O_RAM_RE <= 1'b0;
         O_RAM_ADDR <= '0;
         O_RAM_WDATA <= '0;
         ram_rd_pend <= 1'b0;
         O_RDATA <= '0;
         O_RDATA_VALID <= 1'b0;
      end else begin
         O_RAM_WE <= dat_wr;
         O_RAM_RE <= dat_rd;
         if (dat_wr || dat_rd)
            O_RAM_ADDR <= {ptr.bank, ram_col};
         if (dat_wr)
            O_RAM_WDATA <= swapped;
         ram_rd_pend <= dat_rd;
         O_RDATA_VALID <= ram_rd_pend || cmd_rd;
         if (ram_rd_pend)
            O_RDATA <= I_RAM_RDATA;
         else if (cmd_rd)
            O_RDATA <= status;
      end
   end

   assign O_CTRL = ctrl;
   assign O_POINTERS = ptr;
   assign O_DRIVERS_ON = |ctrl.driver_enable;

   wire logic wrap_case = dat_wr && ctrl.increment_setup[0] &&
                          !ctrl.increment_setup[1] &&
                          ptr.column == ctrl.column_limit;

   // Each check names its own clock so it can sit beside its logic
   halt_col_a: assert property (
      @(posedge I_SYS_CLK) disable iff (I_RST)
      dat_wr && !ctrl.increment_setup[0] && !ctrl.increment_setup[1] &&
      ptr.column == ctrl.column_limit |=> $stable(ptr))
      else $error("column moved past limit without wrap");
   wrap_col_a: assert property (
      @(posedge I_SYS_CLK) disable iff (I_RST)
      wrap_case |=> ptr.column == 7'h0 &&
      ptr.bank == ($past(ctrl.increment_setup[2]) ?
      $past(ptr.bank) - 5'h1 : $past(ptr.bank) + 5'h1))
      else $error("wrap did not reset column and step bank");
   bank_wrap_a: assert property (
      @(posedge I_SYS_CLK) disable iff (I_RST)
      wrap_case && !ctrl.increment_setup[2] && ptr.bank == 5'h1f
      |=> ptr.bank == 5'h0)
      else $error("bank did not wrap to 0");
   status_byte_a: assert property (
      @(posedge I_SYS_CLK) disable iff (I_RST)
      cmd_rd |=> O_RDATA_VALID && O_RDATA[0] &&
      O_RDATA[3] == $past(ctrl.increment_setup[0]))
      else $error("status byte wrong");
   reset_block_a: assert property (
      @(posedge I_SYS_CLK) disable iff (I_RST)
      I_RESET_PENDING |=> !O_RAM_WE && !O_RAM_RE && $stable(ctrl))
      else $error("access taken during reset");
   read_data_a: assert property (
      @(posedge I_SYS_CLK) disable iff (I_RST)
      dat_rd |=> O_RAM_RE ##1 O_RDATA_VALID &&
      O_RDATA == $past(I_RAM_RDATA))
      else $error("read data not returned in two cycles");
   swap_bits_a: assert property (
      @(posedge I_SYS_CLK) disable iff (I_RST)
      dat_wr && ctrl.bit_pair_swap |=>
      O_RAM_WDATA == {$past(b[1:0]), $past(b[3:2]), $past(b[5:4]),
      $past(b[7:6])})
      else $error("bit pair swap wrong");
   param_byte_a: assert property (
      @(posedge I_SYS_CLK) disable iff (I_RST)
      cmd_wr && state == lhcd_pkg::ST_LIMIT |=>
      state == lhcd_pkg::ST_OPCODE && $stable(ptr) &&
      ctrl.column_limit == $past(b[6:0]))
      else $error("parameter byte misdecoded");
   bias_param_a: assert property (
      @(posedge I_SYS_CLK) disable iff (I_RST)
      cmd_wr && state == lhcd_pkg::ST_BIAS |=>
      state == lhcd_pkg::ST_OPCODE && $stable(ptr) &&
      ctrl.bias_gain == $past(b[7:6]) && ctrl.bias_trim == $past(b[5:0]))
      else $error("bias parameter byte misdecoded");
   skip_mid_a: assert property (
      @(posedge I_SYS_CLK) disable iff (I_RST)
      dat_wr && ctrl.driver_enable == 3'h5 && !ctrl.increment_setup[1] &&
      ptr.column == 7'h2f && ctrl.column_limit > 7'h2f
      |=> ptr.column == 7'h50)
      else $error("partial mode did not skip middle columns");
   col_load_a: assert property (
      @(posedge I_SYS_CLK) disable iff (I_RST)
      op_cmd && b[7:4] == 4'h0 |=> ptr.column[3:0] == $past(b[3:0]) &&
      ptr.column[6:4] == $past(ptr.column[6:4]) &&
      ptr.bank == $past(ptr.bank))
      else $error("column low load wrong");
   bank_load_a: assert property (
      @(posedge I_SYS_CLK) disable iff (I_RST)
      op_cmd && b[7:4] == 4'h7 |=> ptr.bank[4] == $past(b[0]) &&
      ptr.bank[3:0] == $past(ptr.bank[3:0]))
      else $error("bank high load wrong");
   cmd_no_ram_a: assert property (
      @(posedge I_SYS_CLK) disable iff (I_RST)
      cmd_wr |=> !O_RAM_WE)
      else $error("command byte reached display RAM");
   data_route_a: assert property (
      @(posedge I_SYS_CLK) disable iff (I_RST)
      dat_wr |=> O_RAM_WE && $stable(ctrl) && state == $past(state))
      else $error("data byte decoded as command");
   mux_set_a: assert property (
      @(posedge I_SYS_CLK) disable iff (I_RST)
      op_cmd && b[7:2] == 6'h08 |=> ctrl.row_multiplex == $past(b[1:0]))
      else $error("row multiplex not set");
   scroll_hi_a: assert property (
      @(posedge I_SYS_CLK) disable iff (I_RST)
      op_cmd && b[7:3] == 5'h0a |=>
      ctrl.scroll_offset == {$past(b[2:0]), $past(ctrl.scroll_offset[3:0])})
      else $error("scroll offset high load wrong");
   inc_setup_a: assert property (
      @(posedge I_SYS_CLK) disable iff (I_RST)
      op_cmd && b[7:3] == 5'h11 |=> ctrl.increment_setup == $past(b[2:0]))
      else $error("increment setup not set");

   wrap_seen_c: cover property (@(posedge I_SYS_CLK) wrap_case);
   limit_cmd_c: cover property (@(posedge I_SYS_CLK)
      cmd_wr && state == lhcd_pkg::ST_LIMIT);
   status_rd_c: cover property (@(posedge I_SYS_CLK) cmd_rd);
   bias_cmd_c: cover property (@(posedge I_SYS_CLK)
      cmd_wr && state == lhcd_pkg::ST_BIAS);
   skip_seen_c: cover property (@(posedge I_SYS_CLK)
      dat_wr && ctrl.driver_enable == lhcd_pkg::DE_PARTIAL);
endmodule

// >>> lhcd_ram_model.sv
// Behavioural display RAM read port facing the decoder.
// Assumes the decoder samples read data while its read request stands.
`timescale 1ns/1ps
module lhcd_ram_model (
   input  wire logic        i_clk,
   input  wire logic        i_re,
   input  wire logic [11:0] i_addr,
   output logic      [7:0]  o_rdata
);
   logic [7:0] churn = 8'h00;

   // Lines churn outside a read so stale data can never pass for an answer
   always @(posedge i_clk) begin
      churn <= churn + 8'h35;
   end

   assign o_rdata = i_re ? (i_addr[7:0] ^ 8'h5a) : churn;
endmodule

// >>> test_lhcd_decoder.sv
// Self-checking bench for the LCD host command decoder.
// Assumes a 40 MHz clock and the behavioural RAM model on the read port.
`timescale 1ns/1ps
module test_lhcd_decoder;
   typedef struct {logic [7:0] cmd; int sel; logic [7:0] exp;} lhcd_row_t;
   logic                 clk = 1'b0;
   logic                 rst = 1'b1;
   logic                 wr = 1'b0;
   logic                 rd = 1'b0;
   logic                 cd = 1'b0;
   logic [7:0]           wdata = 8'h00;
   logic                 busy = 1'b0;
   logic                 rpend = 1'b0;
   logic [7:0]           ram_rdata;
   logic [7:0]           rdata;
   logic                 rvalid;
   logic                 ram_we;
   logic                 ram_re;
   logic [11:0]          ram_addr;
   logic [7:0]           ram_wdata;
   lhcd_pkg::lhcd_ctrl_t ctrl;
   lhcd_pkg::lhcd_addr_t ptr;
   logic                 drv_on;
   logic [11:0]          rd_addr;
   logic                 rd_re;
   int                   bad_count = 0;
   int                   checks = 0;
   lhcd_row_t rows [21] = '{
      '{8'h21, 0, 8'h01},
      '{8'h26, 1, 8'h02},
      '{8'h29, 2, 8'h0d},
      '{8'h2c, 2, 8'h01},
      '{8'h32, -1, 8'h00},
      '{8'h8b, 3, 8'h0b},
      '{8'h47, 4, 8'h07},
      '{8'h53, 4, 8'h37},
      '{8'h81, 6, 8'h00},
      '{8'ha5, 5, 8'ha5},
      '{8'h8d, 6, 8'h05},
      '{8'h97, 7, 8'h07},
      '{8'ha2, 8, 8'h02},
      '{8'ha5, 9, 8'h02},
      '{8'ha7, 9, 8'h03},
      '{8'had, 10, 8'h05},
      '{8'hc7, 11, 8'h07},
      '{8'h0a, 12, 8'h0a},
      '{8'h13, 12, 8'h3a},
      '{8'h6b, 13, 8'h0b},
      '{8'h71, 13, 8'h1b}
   };

   always #12.5 clk = ~clk;

   lhcd_decoder u_dut (
      .I_SYS_CLK(clk), .I_RST(rst), .I_WR_STB(wr), .I_RD_STB(rd),
      .I_CD(cd), .I_WDATA(wdata), .I_BUSY(busy), .I_RESET_PENDING(rpend),
      .I_RAM_RDATA(ram_rdata), .O_RDATA(rdata), .O_RDATA_VALID(rvalid),
      .O_RAM_WE(ram_we), .O_RAM_RE(ram_re), .O_RAM_ADDR(ram_addr),
      .O_RAM_WDATA(ram_wdata), .O_CTRL(ctrl), .O_POINTERS(ptr),
      .O_DRIVERS_ON(drv_on));

   lhcd_ram_model u_ram (
      .i_clk(clk), .i_re(ram_re), .i_addr(ram_addr), .o_rdata(ram_rdata));

   task automatic compare(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      if (bad_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // One byte per call; the idle edge between calls keeps strobes clean
   task automatic put(input logic c, input logic [7:0] b);
      @(posedge clk);
      wr <= 1'b1;
      cd <= c;
      wdata <= b;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask

   task automatic get(input logic c);
      int n;
      n = 0;
      @(posedge clk);
      rd <= 1'b1;
      cd <= c;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      rd_addr = ram_addr;
      rd_re = ram_re;
      while (rvalid !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 4) begin
         bad_count++;
         complete_run();
      end
   endtask

   function automatic logic [7:0] pick(input int s);
      case (s)
         0: pick = 8'(ctrl.row_multiplex);
         1: pick = 8'(ctrl.temp_slope);
         2: pick = 8'(ctrl.power_config);
         3: pick = 8'(ctrl.column_limit);
         4: pick = 8'(ctrl.scroll_offset);
         5: pick = {ctrl.bias_gain, ctrl.bias_trim};
         6: pick = 8'(ctrl.increment_setup);
         7: pick = 8'(ctrl.fixed_pairs);
         8: pick = 8'(ctrl.line_rate);
         9: pick = 8'({ctrl.force_all_on, ctrl.invert_pixels});
         10: pick = 8'(ctrl.driver_enable);
         11: pick = 8'({ctrl.row_mirror, ctrl.column_mirror,
                        ctrl.bit_pair_swap});
         12: pick = 8'(ptr.column);
         13: pick = 8'(ptr.bank);
         default: pick = 8'h00;
      endcase
   endfunction

   function automatic lhcd_pkg::lhcd_ctrl_t rst_ctrl();
      lhcd_pkg::lhcd_ctrl_t e;
      e = '0;
      e.row_multiplex = 2'h3;
      e.bias_gain = 2'h3;
      e.bias_trim = 6'h10;
      e.power_config = 4'hc;
      e.column_limit = 7'h7f;
      return e;
   endfunction

   initial begin
      repeat (4) @(posedge clk);
      compare(ctrl, rst_ctrl());
      compare(ptr, 12'h000);
      rst <= 1'b0;
      foreach (rows[i]) begin
         put(1'b0, rows[i].cmd);
         if (rows[i].sel >= 0)
            compare(pick(rows[i].sel), rows[i].exp);
      end
      @(posedge clk) busy <= 1'b1;
      get(1'b0);
      compare(rdata, 8'hed);
      compare(rd_re, 1'b0);
      @(posedge clk) busy <= 1'b0;
      put(1'b0, 8'hc1);
      put(1'b0, 8'h32);
      put(1'b0, 8'h5f);
      put(1'b0, 8'h0f);
      put(1'b0, 8'h12);
      put(1'b0, 8'h60);
      put(1'b0, 8'h70);
      put(1'b1, 8'he4);
      compare(ram_we, 1'b1);
      compare(ram_addr, 12'h02f);
      compare(ram_wdata, 8'h1b);
      compare(ptr.column, 7'h50);
      put(1'b0, 8'h0f);
      put(1'b0, 8'h15);
      put(1'b1, 8'h00);
      compare(ptr, 12'hf80);
      put(1'b0, 8'h88);
      put(1'b0, 8'h0f);
      put(1'b0, 8'h15);
      put(1'b1, 8'h00);
      compare(ptr, 12'hfdf);
      put(1'b0, 8'h89);
      put(1'b1, 8'h00);
      compare(ptr, 12'h000);
      put(1'b0, 8'h6f);
      put(1'b0, 8'h71);
      put(1'b0, 8'hc2);
      put(1'b0, 8'h00);
      put(1'b0, 8'h11);
      get(1'b1);
      compare(rd_addr, 12'hfef);
      compare(rdata, 8'hb5);
      compare(rd_re, 1'b1);
      put(1'b0, 8'h8b);
      put(1'b0, 8'h01);
      put(1'b0, 8'h11);
      put(1'b1, 8'h55);
      compare(ptr, 12'h012);
      put(1'b1, 8'h55);
      compare(ptr, 12'h092);
      compare(drv_on, 1'b1);
      put(1'b0, 8'ha8);
      compare(drv_on, 1'b0);
      @(posedge clk) rpend <= 1'b1;
      put(1'b0, 8'h6f);
      compare(ptr, 12'h092);
      put(1'b1, 8'h00);
      compare(ram_we, 1'b0);
      // Mid-run reset with a parameter byte still owed
      @(posedge clk) rpend <= 1'b0;
      put(1'b0, 8'h81);
      @(posedge clk) rst <= 1'b1;
      @(posedge clk) rst <= 1'b0;
      #1;
      compare(ctrl, rst_ctrl());
      compare(ptr, 12'h000);
      put(1'b0, 8'h20);
      compare(ctrl.row_multiplex, 2'h0);
      complete_run();
   end

   // Hang guard
   initial begin
      #200000;
      bad_count++;
      complete_run();
   end
endmodule
